/* File: design/sdcr_cfg.svh */
// constants for the card host configuration and data-control register bank
// assumes a 32-bit classic wishbone slave with byte addresses
//
// Operation
// R1 - bus lane field 00 gives one data line, 01 gives four, 10 and 11 are reserved.
// R2 - outbound queue word size 00/01/10/11 selects 8/16/32/64-bit writes from the bus side.
// R3 - inbound queue word size 00/01/10/11 selects 8/16/32/64-bit reads on the bus side.
// R4 - software sets each queue word size before any transfer through that queue.
// R5 - software flushes a queue whenever its word size is changed.
// R6 - interface enable 0 holds the card interface idle, 1 lets it run.
// R7 - chunk exponent gives a block of two to that power in bytes, value 0 reserved.
// R8 - a transfer is split into successive chunks of the block length.
// R9 - software sets data control before writing the command code register.
// R10 - byte count gives the bytes moved before data completion is signalled.
// R11 - software makes the byte count a whole multiple of the block length.
// R12 - reading the byte count returns the bytes still to transfer.
// R13 - the data path idles until go is 1; way 0 reads the card, 1 writes it.
// R14 - a 32-bit command parameter is held and reads back as last written.
// R15 - a write to the command code register starts a command transfer.
// R16 - reserved bits read as zero and ignore writes.
`ifndef SDCR_CFG_SVH
`define SDCR_CFG_SVH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define SDCR_OFS_CFG   8'h10
`define SDCR_OFS_DCTL  8'h14
`define SDCR_OFS_PARM  8'h18
`define SDCR_OFS_CODE  8'h1c

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define SDCR_CFG_LANE_HI  13
`define SDCR_CFG_LANE_LO  12
`define SDCR_CFG_OQ_HI    9
`define SDCR_CFG_OQ_LO    8
`define SDCR_CFG_IQ_HI    7
`define SDCR_CFG_IQ_LO    6
`define SDCR_CFG_EN       5
`define SDCR_CFG_EXP_HI   3
`define SDCR_CFG_EXP_LO   0
`define SDCR_CFG_MASK     32'h0000_33ef
`define SDCR_DC_CNT_HI    31
`define SDCR_DC_CNT_LO    16
`define SDCR_DC_GO        1
`define SDCR_DC_WAY       0
`define SDCR_CODE_MASK    32'h0000_077f
`define SDCR_RST_VAL      32'h0000_0000

`endif

/* File: design/sdcr_pkg.sv */
// types for the card host register bank
// assumes nothing of its surroundings
package sdcr_pkg;
  typedef enum logic [2:0] {
    SDCR_IDLE = 3'b001,
    SDCR_RUN  = 3'b010,
    SDCR_WAIT = 3'b100
  } sdcr_st_t;
endpackage

/* File: design/sdcr_regs.sv */
// card host config/data-control registers with link-side byte mover
// assumes classic wishbone on i_clk, link clock from card side, bytes pulse on link
//
// Register access over Wishbone is this design's own decision.
`include "sdcr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sdcr_regs
  import sdcr_pkg::*;
(
  // system
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // settings toward the card engine
  output logic      [1:0]  o_bus_lanes,
  output logic      [1:0]  o_outq_size,
  output logic      [1:0]  o_inq_size,
  output logic             o_if_enable,
  output logic      [31:0] o_cmd_param,
  output logic             o_cmd_start,
  output logic      [10:0] o_cmd_code,
  output logic             o_data_done,
  // link side
  input  wire logic        i_link_clk,
  input  wire logic        i_link_byte,
  output logic             o_link_active,
  output logic             o_link_way,
  output logic             o_link_blk_end
);

  sdcr_st_t    st_r, st_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        go_r, go_nxt, way_r, way_nxt;
  logic [31:0] parm_r, parm_nxt, rd_nxt, rdat_r;
  logic [10:0] code_r, code_nxt;
  logic        ack_r, ack_nxt, start_r, start_nxt, done_r, done_nxt;
  logic [15:0] blk_r, blk_nxt;
  logic        req_r, req_nxt;
  logic        dec_r, dec_nxt;
  logic [2:0]  ack_sync_r;
  logic [1:0]  run_sync_r;

  // link-domain state, then the bus write mask and access strobes
  logic [1:0]  rst_sync_l_r;
  logic [1:0]  req_sync_r;
  logic [1:0]  req_sync_nxt;
  logic        run_l_r;
  logic        run_l_nxt;
  logic        tog_l_r;
  logic        tog_l_nxt;
  logic        bend_l_r;
  logic        bend_l_nxt;
  logic [15:0] bcnt_l_r;
  logic [15:0] bcnt_l_nxt;
  logic [31:0] wmask;
  logic        wr, rd_go;

  // --------------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------------
  assign wr    = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
  assign rd_go = i_wb_cyc && i_wb_stb && !ack_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{i_wb_sel[i]}};
    end
  end

  // --------------------------------------------------------------------------
  // register state and data mover
  // --------------------------------------------------------------------------
  always_comb begin
    cfg_nxt   = cfg_r;
    cnt_nxt   = cnt_r;
    go_nxt    = go_r;
    way_nxt   = way_r;
    parm_nxt  = parm_r;
    code_nxt  = code_r;
    start_nxt = 1'b0;
    done_nxt  = 1'b0;
    st_nxt    = st_r;
    blk_nxt   = blk_r;
    req_nxt   = req_r;
    ack_nxt   = rd_go;
    rd_nxt    = rdat_r;
    if (rd_go) begin
      case (i_wb_adr)
        `SDCR_OFS_CFG:  rd_nxt = cfg_r;
        `SDCR_OFS_DCTL: rd_nxt = {cnt_r, 14'h0000, go_r, way_r}; // [R12] [R16]
        `SDCR_OFS_PARM: rd_nxt = parm_r;                         // [R14]
        `SDCR_OFS_CODE: rd_nxt = {21'h000000, code_r};
        default:        rd_nxt = 32'h0000_0000;
      endcase
    end
    // a byte moved on the link lowers the remaining count
    if (dec_r && cnt_r != 16'h0000) begin
      cnt_nxt = cnt_r - 16'h0001;                                // [R10]
      if (blk_r == 16'h0001) begin
        blk_nxt = 16'h0001 << cfg_r[`SDCR_CFG_EXP_HI:`SDCR_CFG_EXP_LO]; // [R8]
      end else begin
        blk_nxt = blk_r - 16'h0001;
      end
      if (cnt_r == 16'h0001) begin
        done_nxt = 1'b1;                                         // [R10]
        go_nxt   = 1'b0;
      end
    end
    if (wr) begin
      case (i_wb_adr)
        `SDCR_OFS_CFG:
          cfg_nxt = ((cfg_r & ~wmask) | (i_wb_dat & wmask)) & `SDCR_CFG_MASK; // [R16]
        `SDCR_OFS_DCTL: begin
          if (i_wb_sel[3:2] == 2'b11) begin
            cnt_nxt = i_wb_dat[`SDCR_DC_CNT_HI:`SDCR_DC_CNT_LO];
          end
          if (i_wb_sel[0]) begin
            go_nxt  = i_wb_dat[`SDCR_DC_GO];
            way_nxt = i_wb_dat[`SDCR_DC_WAY];                   // [R13]
          end
        end
        `SDCR_OFS_PARM:
          parm_nxt = (parm_r & ~wmask) | (i_wb_dat & wmask);  // [R14]
        `SDCR_OFS_CODE: begin
          code_nxt  = 11'((({21'h000000, code_r} & ~wmask) | (i_wb_dat & wmask))
                          & `SDCR_CODE_MASK);
          start_nxt = cfg_r[`SDCR_CFG_EN];                       // [R15] [R6]
        end
        default: ;
      endcase
    end
    // link request: handshake level toward the link domain
    case (st_r)
      SDCR_IDLE: begin
        if (go_r && cfg_r[`SDCR_CFG_EN] && cnt_r != 16'h0000) begin // [R13] [R6]
          st_nxt  = SDCR_RUN;
          req_nxt = 1'b1;
          blk_nxt = 16'h0001 << cfg_r[`SDCR_CFG_EXP_HI:`SDCR_CFG_EXP_LO]; // [R7]
        end
      end
      SDCR_RUN: begin
        if (!go_r || !cfg_r[`SDCR_CFG_EN] || cnt_nxt == 16'h0000) begin // [R6]
          st_nxt  = SDCR_WAIT;
          req_nxt = 1'b0;
        end
      end
      SDCR_WAIT: begin
        // wait for the link to go quiet so no stray byte lands on a new count
        if (!run_sync_r[1] && (ack_sync_r[2] == ack_sync_r[1]) && !dec_r) begin
          st_nxt = SDCR_IDLE;
        end
      end
      default: st_nxt = SDCR_IDLE;
    endcase
    dec_nxt = ack_sync_r[2] ^ ack_sync_r[1];
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cfg_r   <= `SDCR_RST_VAL;
      cnt_r   <= 16'h0000;
      go_r    <= 1'b0;
      way_r   <= 1'b0;
      parm_r  <= `SDCR_RST_VAL;
      code_r  <= 11'h000;
      ack_r   <= 1'b0;
      start_r <= 1'b0;
      done_r  <= 1'b0;
      rdat_r  <= `SDCR_RST_VAL;
      st_r    <= SDCR_IDLE;
      blk_r   <= 16'h0001;
      req_r   <= 1'b0;
      dec_r   <= 1'b0;
      ack_sync_r <= 3'b000;
      run_sync_r <= 2'b00;
    end else begin
      cfg_r   <= cfg_nxt;
      cnt_r   <= cnt_nxt;
      go_r    <= go_nxt;
      way_r   <= way_nxt;
      parm_r  <= parm_nxt;
      code_r  <= code_nxt;
      ack_r   <= ack_nxt;
      start_r <= start_nxt;
      done_r  <= done_nxt;
      rdat_r  <= rd_nxt;
      st_r    <= st_nxt;
      blk_r   <= blk_nxt;
      req_r   <= req_nxt;
      dec_r   <= dec_nxt;
      ack_sync_r <= {ack_sync_r[1:0], tog_l_r};
      run_sync_r <= {run_sync_r[0], run_l_r};
    end
  end

  // --------------------------------------------------------------------------
  // link domain: byte pulses become toggles back to the bus domain
  // --------------------------------------------------------------------------
  // reset reaches the link logic through two flops of its own
  always_ff @(posedge i_link_clk) begin
    rst_sync_l_r <= {rst_sync_l_r[0], i_reset_n};
  end

  always_comb begin
    req_sync_nxt = {req_sync_r[0], req_r};
    run_l_nxt    = req_sync_r[1];
    tog_l_nxt    = tog_l_r;
    bend_l_nxt   = 1'b0;
    bcnt_l_nxt   = bcnt_l_r;
    if (!req_sync_r[1]) begin
      // exponent is held static by software while a transfer runs
      bcnt_l_nxt = 16'h0001 << cfg_r[`SDCR_CFG_EXP_HI:`SDCR_CFG_EXP_LO]; // [R7]
    end else if (i_link_byte) begin
      tog_l_nxt = ~tog_l_r;
      if (bcnt_l_r == 16'h0001) begin
        bend_l_nxt = 1'b1;                                             // [R8]
        bcnt_l_nxt = 16'h0001 << cfg_r[`SDCR_CFG_EXP_HI:`SDCR_CFG_EXP_LO];
      end else begin
        bcnt_l_nxt = bcnt_l_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!rst_sync_l_r[1]) begin
      req_sync_r <= 2'b00;
      run_l_r    <= 1'b0;
      tog_l_r    <= 1'b0;
      bend_l_r   <= 1'b0;
      bcnt_l_r   <= 16'h0001;
    end else begin
      req_sync_r <= req_sync_nxt;
      run_l_r    <= run_l_nxt;
      tog_l_r    <= tog_l_nxt;
      bend_l_r   <= bend_l_nxt;
      bcnt_l_r   <= bcnt_l_nxt;
    end
  end

  assign o_wb_dat       = rdat_r;
  assign o_wb_ack       = ack_r;
  assign o_bus_lanes    = cfg_r[`SDCR_CFG_LANE_HI:`SDCR_CFG_LANE_LO]; // [R1]
  assign o_outq_size    = cfg_r[`SDCR_CFG_OQ_HI:`SDCR_CFG_OQ_LO];     // [R2]
  assign o_inq_size     = cfg_r[`SDCR_CFG_IQ_HI:`SDCR_CFG_IQ_LO];     // [R3]
  assign o_if_enable    = cfg_r[`SDCR_CFG_EN];                        // [R6]
  assign o_cmd_param    = parm_r;
  assign o_cmd_start    = start_r;
  assign o_cmd_code     = code_r;
  assign o_data_done    = done_r;
  assign o_link_active  = run_l_r;
  assign o_link_way     = way_r;
  assign o_link_blk_end = bend_l_r;

endmodule
`default_nettype wire

/* File: sim/sdcr_card_model.sv */
// card-side byte source on the link clock
// assumes the dut link activity output
`timescale 1ns/1ps
`default_nettype none
module sdcr_card_model (
  input  wire logic i_link_clk,
  input  wire logic i_active,
  input  wire logic i_slow,
  output logic      o_byte
);
  logic ph = 1'b0;
  initial o_byte = 1'b0;
  // one byte per edge, every other edge when slow
  always @(posedge i_link_clk) begin
    ph <= ~ph;
    o_byte <= i_active && (!i_slow || ph);
  end
endmodule
`default_nettype wire

/* File: sim/sdcr_regs_monitor.sv */
// checker on the register bank ports
// assumes binding to sdcr_regs from the bench
`include "sdcr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdcr_regs_monitor (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic [1:0]  o_bus_lanes,
  input wire logic        o_if_enable,
  input wire logic [31:0] o_cmd_param,
  input wire logic        o_cmd_start
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic wr = o_wb_ack && i_wb_we;
  wire logic rd = o_wb_ack && !i_wb_we;
  // --------
  // properties
  // --------
  sequence code_wr;
    wr && i_wb_adr == `SDCR_OFS_CODE && o_if_enable;
  endsequence
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("late ack");
  lane_write_a: assert property (wr && i_wb_adr == `SDCR_OFS_CFG && i_wb_sel[1]
    |=> o_bus_lanes == $past(i_wb_dat[13:12])) else $error("lanes not written");
  cfg_read_a: assert property (rd && i_wb_adr == `SDCR_OFS_CFG |-> o_wb_dat[5] == o_if_enable
    && (o_wb_dat & ~`SDCR_CFG_MASK) == 0) else $error("bad config read");
  param_write_a: assert property (wr && i_wb_adr == `SDCR_OFS_PARM && &i_wb_sel
    |=> o_cmd_param == $past(i_wb_dat)) else $error("parameter not written");
  param_read_a: assert property (rd && i_wb_adr == `SDCR_OFS_PARM |-> o_wb_dat == o_cmd_param)
    else $error("bad parameter read");
  unmapped_read_a: assert property (rd && i_wb_adr == 8'h00 |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  start_gate_a: assert property (o_cmd_start |-> o_if_enable)
    else $error("start while disabled");
  start_follow_a: assert property (code_wr |-> ##[0:2] o_cmd_start)
    else $error("no start after code write");
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// bench for the card host register bank
// assumes dut, card model and checker compiled first
`include "sdcr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, lclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slow = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wd = 0, q, rdat, param;
  logic [1:0]  lanes, oq, iq;
  logic [10:0] code;
  logic        ack, en, start, done, act, way, bend, lbyte;
  int          fails = 0, comparisons = 0, starts = 0, dones = 0, bends = 0;
  always @(posedge lclk) if (bend === 1'b1) bends++;
  always #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
    if (done === 1'b1) dones++;
  end
  sdcr_regs dut (.i_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_bus_lanes(lanes), .o_outq_size(oq), .o_inq_size(iq),
    .o_if_enable(en), .o_cmd_param(param), .o_cmd_start(start), .o_cmd_code(code),
    .o_data_done(done), .i_link_clk(lclk), .i_link_byte(lbyte),
    .o_link_active(act), .o_link_way(way), .o_link_blk_end(bend));
  sdcr_card_model card (.i_link_clk(lclk), .i_active(act), .i_slow(slow), .o_byte(lbyte));
  // --------
  // tasks
  // --------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, s};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n == 20) begin
      fails++;
      close_out();
    end
  endtask
  initial begin
    logic [31:0] v;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wb(0, `SDCR_OFS_CFG + 8'(4 * i), 32'h0, 4'hf);
      check("reset value", q, 32'h0);
    end
    wb(1, `SDCR_OFS_CFG, 32'hffff_ffff, 4'hf);
    wb(0, `SDCR_OFS_CFG, 32'h0, 4'hf);
    check("config reserved", q, `SDCR_CFG_MASK);
    for (int i = 0; i < 4; i++) begin
      v = {18'h0, 2'(i), 2'h0, 2'(i), 2'(i), 2'h0, 4'(i + 1)};
      wb(1, `SDCR_OFS_CFG, v, 4'hf);
      check("fields", {lanes, oq, iq, en}, {25'h0, {3{2'(i)}}, 1'b0});
      wb(0, `SDCR_OFS_CFG, 32'h0, 4'hf);
      check("config read", q, v);
    end
    $display("config test done");
    wb(1, `SDCR_OFS_PARM, 32'ha5c3_1e7f, 4'hf);
    wb(1, `SDCR_OFS_PARM, 32'h0, 4'h1);
    wb(0, `SDCR_OFS_PARM, 32'h0, 4'hf);
    check("parameter", q, 32'ha5c3_1e00);
    wb(1, 8'h00, 32'hffff_ffff, 4'hf);
    wb(0, 8'h00, 32'h0, 4'hf);
    check("unmapped", q, 32'h0);
    $display("parameter test done");
    wb(1, `SDCR_OFS_CODE, 32'h0000_0011, 4'hf);
    repeat (3) @(posedge clk);
    check("start disabled", starts, 0);
    wb(1, `SDCR_OFS_CFG, 32'h0000_0020, 4'hf);
    wb(1, `SDCR_OFS_CODE, 32'h0000_0052, 4'hf);
    repeat (3) @(posedge clk);
    check("start enabled", starts, 1);
    check("command code", code, 32'h0000_0052);
    wb(0, `SDCR_OFS_CODE, 32'h0, 4'hf);
    check("code read", q, 32'h0000_0052);
    $display("command test done");
    for (int w = 0; w < 2; w++) begin
      slow <= w[0];
      wb(1, `SDCR_OFS_CFG, 32'h0000_0001, 4'hf);
      wb(1, `SDCR_OFS_DCTL, 32'h0004_0002 | w, 4'hf);
      repeat (30) @(posedge clk);
      wb(0, `SDCR_OFS_DCTL, 32'h0, 4'hf);
      check("held idle", q, 32'h0004_0002 | w);
      wb(1, `SDCR_OFS_CFG, 32'h0000_0021, 4'hf);
      for (int n = 0; n < 500 && dones <= w; n++) @(posedge clk);
      check("done count", dones, w + 1);
      wb(0, `SDCR_OFS_DCTL, 32'h0, 4'hf);
      check("remaining", q, w);
      check("way", way, w);
      check("block ends", 32'(bends >= 2 * (w + 1)), 1);
    end
    $display("transfer test done");
    close_out();
  end
endmodule
bind sdcr_regs sdcr_regs_monitor mon (.*);
`default_nettype wire
